// ==== verilog/sofb_pkg.sv ====
// sofb_pkg: shared constants, types and register map for the safety
// output function blocks.
// assumes a 25 MHz system clock and an AXI4-Lite register bus.
`default_nettype none
package sofb_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned NCH = 4;
  localparam int unsigned NRELAY = 4;
  localparam int unsigned NPROBE = 32;
  localparam int unsigned NPROBE_OLD = 16;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CHCFG = 8'h04;
  localparam logic [7:0] OFS_FBKTIME = 8'h08;
  localparam logic [7:0] OFS_NODES = 8'h0C;
  localparam logic [7:0] OFS_RLYCFG = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_PROBE = 8'h18;
  // ctrl fields
  localparam int unsigned CTRL_GRP_LSB = 0;
  localparam int unsigned CTRL_FWNEW_BIT = 2;
  localparam int unsigned CTRL_CLRERR_BIT = 3;
  // per-channel config byte fields
  localparam int unsigned CF_RSTEN = 0;
  localparam int unsigned CF_MONRST = 1;
  localparam int unsigned CF_FBKMON = 2;
  localparam int unsigned CF_ERREN = 3;
  localparam int unsigned CF_NOTP = 4;
  localparam int unsigned CF_FBKUNC = 5;
  // relay config byte fields
  localparam int unsigned RC_CAT_LSB = 0;
  localparam int unsigned RC_MANUAL = 2;
  localparam int unsigned RC_EDM = 3;
  // reset values and test pulse period
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CHCFG_RST = 32'h0000_0000;
  localparam logic [15:0] FBKTIME_RST = 16'h0064;
  localparam logic [31:0] RLYCFG_RST = 32'h0000_0000;
  localparam logic [14:0] TP_PERIOD = 15'h61A8;

  typedef enum logic [1:0] {GRP_FOUR_SINGLE, GRP_TWO_DOUBLE, GRP_MIXED}
    sofb_grp_e;
  typedef enum logic [1:0] {CAT_1, CAT_2, CAT_4} sofb_cat_e;

  typedef struct packed {
    logic fbkunc;
    logic notp;
    logic erren;
    logic fbkmon;
    logic monrst;
    logic rsten;
  } sofb_chcfg_s;
endpackage : sofb_pkg
`default_nettype wire

// ==== verilog/sofb_top.sv ====
// sofb_top: safety switching outputs, status/probe outputs and relay
// outputs, with an AXI4-Lite register port.
// assumes all field inputs already synchronous to CLK.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`default_nettype none
// What this block does
// [RULE_01] manual reset accepts on rising edge
// [RULE_02] monitored reset needs full rise-fall pulse
// [RULE_03] no reset: output follows input
// [RULE_04] dual output: reset after each change
// [RULE_05] single output: reset after each dropout
// [RULE_06] dual channels follow block input
// [RULE_07] feedback inverse of output within window
// [RULE_08] feedback fault forces low, flashes indicator
// [RULE_09] error flag raised on feedback fault
// [RULE_10] error flag latched until reset operator
// [RULE_11] external circuit ties restart feedback high
// [RULE_12] restart feedback present only if needed
// [RULE_13] four channels: four, two-two, or mixed
// [RULE_14] test-pulse disable stops test pulses
// [RULE_15] status output follows logic node
// [RULE_16] probe points 32 new firmware, else 16
// [RULE_17] probe states packed into four bytes
// [RULE_18] relay closes when input is one
// [RULE_19] category 1 ignores external feedback
// [RULE_20] category 2 test signal drops on fault
// [RULE_21] category 2 monitoring only automatic start
// [RULE_22] category 4 drives relay pairs
// [RULE_23] millisecond counter times feedback window
module sofb_top
  import sofb_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // safety outputs
  input wire logic [3:0] BLOCK_IN,
  input wire logic [3:0] RESET_IN,
  input wire logic [3:0] CONTACTOR_FEEDBACK,
  input wire logic [3:0] RESTART_FEEDBACK_INPUT,
  output logic [3:0] SAFETY_SWITCHING_OUTPUT,
  output logic [3:0] CLEAR_LED,
  output logic [3:0] ERROR_OUT,
  output logic [3:0] RESTART_FEEDBACK_USED,
  // relay outputs
  input wire logic [3:0] RELAY_IN,
  input wire logic [3:0] RELAY_START,
  input wire logic [3:0] RELAY_READBACK,
  input wire logic [3:0] RELAY_EXT_FEEDBACK,
  output logic [3:0] RELAY_COIL,
  output logic [3:0] OUTPUT_TEST_EQUIPMENT_SIGNAL,
  // non-safety outputs
  output logic [3:0] STATUS_OUT,
  output logic [31:0] FIELDBUS_PROBE
);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a[7:2] == o[7:2]);
  endfunction : hit

  // ---------------- register bus ----------------
  logic [31:0] ctrl_q, chcfg_q, nodes_q, rlycfg_q;
  logic [15:0] fbktime_q;
  logic aw_q, w_q, bv_q, rv_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q, rd_q;
  logic [3:0] ws_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_go, clr_err;
  logic [31:0] wmask, rd_d;
  logic rd_ok, wr_ok;
  logic [3:0] err_q, led_q;

  assign wr_go = aw_q && w_q && !bv_q;
  assign AWREADY = !aw_q && !bv_q;
  assign WREADY = !w_q && !bv_q;
  assign ARREADY = !rv_q;
  assign BVALID = bv_q;
  assign BRESP = bresp_q;
  assign RVALID = rv_q;
  assign RDATA = rd_q;
  assign RRESP = rresp_q;
  assign wmask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
  assign wr_ok = hit(awa_q, OFS_CTRL) || hit(awa_q, OFS_CHCFG)
    || hit(awa_q, OFS_FBKTIME) || hit(awa_q, OFS_NODES)
    || hit(awa_q, OFS_RLYCFG);
  // rule 10 operator: write one to the clear bit, self-clearing
  assign clr_err = wr_go && hit(awa_q, OFS_CTRL)
    && ws_q[0] && wd_q[CTRL_CLRERR_BIT];

  logic [31:0] probe_q;
  logic [3:0] out_q;
  assign rd_ok = hit(ARADDR, OFS_CTRL) || hit(ARADDR, OFS_CHCFG)
    || hit(ARADDR, OFS_FBKTIME) || hit(ARADDR, OFS_NODES)
    || hit(ARADDR, OFS_RLYCFG) || hit(ARADDR, OFS_STATUS)
    || hit(ARADDR, OFS_PROBE);
  assign rd_d =
    hit(ARADDR, OFS_CTRL) ? ctrl_q :
    hit(ARADDR, OFS_CHCFG) ? chcfg_q :
    hit(ARADDR, OFS_FBKTIME) ? {16'h0000, fbktime_q} :
    hit(ARADDR, OFS_NODES) ? nodes_q :
    hit(ARADDR, OFS_RLYCFG) ? rlycfg_q :
    hit(ARADDR, OFS_STATUS) ?
      {16'h0000, OUTPUT_TEST_EQUIPMENT_SIGNAL, led_q, err_q, out_q} :
    hit(ARADDR, OFS_PROBE) ? probe_q : 32'h0000_0000;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0000_0000;
      ws_q <= 4'h0;
      bresp_q <= 2'b00;
      rresp_q <= 2'b00;
      rd_q <= 32'h0000_0000;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_q <= 1'b1;
        awa_q <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_q <= 1'b1;
        wd_q <= WDATA;
        ws_q <= WSTRB;
      end
      if (wr_go)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        bresp_q <= wr_ok ? 2'b00 : 2'b10;
      end
      else if (bv_q && BREADY)
        bv_q <= 1'b0;
      if (ARVALID && ARREADY)
      begin
        rv_q <= 1'b1;
        rd_q <= rd_d;
        rresp_q <= rd_ok ? 2'b00 : 2'b10;
      end
      else if (rv_q && RREADY)
        rv_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ctrl_q <= CTRL_RST;
      chcfg_q <= CHCFG_RST;
      fbktime_q <= FBKTIME_RST;
      nodes_q <= 32'h0000_0000;
      rlycfg_q <= RLYCFG_RST;
    end
    else if (wr_go)
    begin
      if (hit(awa_q, OFS_CTRL))
        ctrl_q <= ((ctrl_q & ~wmask) | (wd_q & wmask))
          & 32'h0000_0007;
      if (hit(awa_q, OFS_CHCFG))
        chcfg_q <= (chcfg_q & ~wmask) | (wd_q & wmask);
      if (hit(awa_q, OFS_FBKTIME))
        fbktime_q <= (fbktime_q & ~wmask[15:0]) | (wd_q[15:0] & wmask[15:0]);
      if (hit(awa_q, OFS_NODES))
        nodes_q <= (nodes_q & ~wmask) | (wd_q & wmask);
      if (hit(awa_q, OFS_RLYCFG))
        rlycfg_q <= (rlycfg_q & ~wmask) | (wd_q & wmask);
    end
  end

  // ---------------- shared millisecond tick ----------------
  logic [14:0] ms_q;
  logic ms_tick;
  // rule 23 base: one tick per millisecond
  assign ms_tick = (ms_q == 15'(MS_CYCLES - 1));
  logic [14:0] tp_q;
  logic tp_phase;
  assign tp_phase = (tp_q == 15'h0000);
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ms_q <= 15'h0000;
      tp_q <= 15'h0000;
    end
    else
    begin
      ms_q <= ms_tick ? 15'h0000 : ms_q + 15'h0001;
      tp_q <= (tp_q == TP_PERIOD) ? 15'h0000 : tp_q + 15'h0001;
    end
  end

  // ---------------- channel grouping ----------------
  logic [1:0] grp;
  logic [3:0] pair_lead;
  logic [3:0] eff_in;
  assign grp = ctrl_q[CTRL_GRP_LSB +: 2];
  // [RULE_13] grouping of channels
  assign pair_lead = (grp == 2'(GRP_TWO_DOUBLE)) ? 4'b0101 :
    (grp == 2'(GRP_MIXED)) ? 4'b0100 : 4'b0000;
  // [RULE_06] both channels take the lead input
  assign eff_in = {pair_lead[2] ? BLOCK_IN[2] : BLOCK_IN[3], BLOCK_IN[2],
    pair_lead[0] ? BLOCK_IN[0] : BLOCK_IN[1], BLOCK_IN[0]};

  // ---------------- per-channel safety outputs ----------------
  logic [3:0] fault_now;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_ch
      sofb_chcfg_s cf;
      logic rst_prev_q, rst_hi_q, armed_q, in_prev_q, want, rise, fall;
      logic [15:0] win_q;
      logic fb_ok, fb_chk;
      assign cf = chcfg_q[g*8 +: 6];
      assign rise = RESET_IN[g] && !rst_prev_q;
      assign fall = !RESET_IN[g] && rst_prev_q;
      // [RULE_12] feedback pin only when needed
      assign RESTART_FEEDBACK_USED[g] = cf.rsten || cf.fbkmon;
      // [RULE_07] inverse feedback expected
      assign fb_ok = (CONTACTOR_FEEDBACK[g] == !out_q[g])
        && (cf.fbkunc || RESTART_FEEDBACK_INPUT[g]);
      assign fb_chk = cf.fbkmon && !fb_ok && (win_q == 16'h0000);
      assign fault_now[g] = fb_chk;
      // [RULE_03] no reset: direct
      assign want = cf.rsten ? (armed_q && eff_in[g]) : eff_in[g];
      always_ff @(posedge CLK or negedge RESETN)
      begin
        if (!RESETN)
        begin
          rst_prev_q <= 1'b0;
          rst_hi_q <= 1'b0;
          armed_q <= 1'b0;
          in_prev_q <= 1'b0;
          out_q[g] <= 1'b0;
          win_q <= 16'h0000;
          err_q[g] <= 1'b0;
          led_q[g] <= 1'b0;
        end
        else
        begin
          rst_prev_q <= RESET_IN[g];
          in_prev_q <= eff_in[g];
          if (rise)
            rst_hi_q <= 1'b1;
          else if (fall)
            rst_hi_q <= 1'b0;
          // [RULE_04] dual drops arm on change
          // [RULE_05] single drops arm on dropout
          if ((pair_lead[g & 2] && (eff_in[g] != in_prev_q))
              || !eff_in[g])
            armed_q <= 1'b0;
          // [RULE_01] manual rising edge
          else if (!cf.monrst && rise)
            armed_q <= 1'b1;
          // [RULE_02] monitored full pulse
          else if (cf.monrst && fall && rst_hi_q)
            armed_q <= 1'b1;
          // [RULE_08] fault forces output low
          out_q[g] <= want && !led_q[g];
          // [RULE_23] window restarts on output change
          if (out_q[g] != (want && !led_q[g]))
            win_q <= fbktime_q;
          else if (ms_tick && win_q != 16'h0000)
            win_q <= win_q - 16'h0001;
          // [RULE_08] indicator latched on fault
          if (clr_err)
            led_q[g] <= 1'b0;
          if (fb_chk)
            led_q[g] <= 1'b1;
          // [RULE_09] error flag on fault
          // [RULE_10] held until clear operator
          if (clr_err)
            err_q[g] <= 1'b0;
          if (fb_chk && cf.erren)
            err_q[g] <= 1'b1;
        end
      end
      // [RULE_14] pulses only when enabled
      assign SAFETY_SWITCHING_OUTPUT[g] = out_q[g]
        && !(tp_phase && !cf.notp);
      assign CLEAR_LED[g] = led_q[g] && ms_q[14];
    end
  endgenerate
  assign ERROR_OUT = err_q;

  // ---------------- status and probe ----------------
  logic [5:0] probe_max;
  // [RULE_15] status follows node
  assign STATUS_OUT = nodes_q[3:0];
  // [RULE_16] point limit by firmware
  assign probe_max = ctrl_q[CTRL_FWNEW_BIT] ? 6'(NPROBE) : 6'(NPROBE_OLD);
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      probe_q <= 32'h0000_0000;
    else
    begin
      // [RULE_17] four bytes, bit per probe
      for (int i = 0; i < NPROBE; i++)
        probe_q[i] <= (6'(i) < probe_max) && nodes_q[i];
    end
  end
  assign FIELDBUS_PROBE = probe_q;

  // ---------------- relay outputs ----------------
  logic [3:0] rly_q, ote_q;
  generate
    for (g = 0; g < 4; g++)
    begin : g_rly
      logic [1:0] cat;
      logic man, external_device_monitoring, lead_in, run, flt;
      assign cat = rlycfg_q[g*8 + RC_CAT_LSB +: 2];
      assign man = rlycfg_q[g*8 + RC_MANUAL];
      // [RULE_19] category 1 no external check
      // [RULE_21] rejected with manual start
      assign external_device_monitoring = rlycfg_q[g*8 + RC_EDM] && (cat != 2'(CAT_1))
        && !(cat == 2'(CAT_2) && man);
      // [RULE_22] pairs share the even input
      assign lead_in = (cat == 2'(CAT_4)) ? RELAY_IN[g & 2] : RELAY_IN[g];
      assign run = lead_in && (!man || RELAY_START[g] || rly_q[g]);
      assign flt = (RELAY_READBACK[g] != rly_q[g])
        || (external_device_monitoring && RELAY_EXT_FEEDBACK[g] == rly_q[g]);
      always_ff @(posedge CLK or negedge RESETN)
      begin
        if (!RESETN)
        begin
          rly_q[g] <= 1'b0;
          ote_q[g] <= 1'b0;
        end
        else
        begin
          // [RULE_18] closed on input one
          rly_q[g] <= run;
          // [RULE_20] test signal drops on fault
          ote_q[g] <= (cat == 2'(CAT_2)) ? !flt : 1'b0;
        end
      end
    end
  endgenerate
  assign RELAY_COIL = rly_q;
  assign OUTPUT_TEST_EQUIPMENT_SIGNAL = ote_q;

endmodule : sofb_top
`default_nettype wire

// ==== tb/sofb_sva.sv ====
// sofb_sva: port checks for sofb_top.
// assumes bind onto sofb_top, one clock domain.
`default_nettype none
module sofb_sva (
  // clock and reset
  input wire logic CLK,
  input wire logic RESETN,
  // bus handshakes
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  // field side
  input wire logic [3:0] BLOCK_IN,
  input wire logic [3:0] SAFETY_SWITCHING_OUTPUT,
  input wire logic [3:0] CLEAR_LED,
  input wire logic [3:0] ERROR_OUT,
  input wire logic [3:0] STATUS_OUT,
  input wire logic [3:0] RELAY_IN,
  input wire logic [3:0] RELAY_COIL
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge CLK); endclocking
  default disable iff (!RESETN);
  out_drop_a: assert property (
    !BLOCK_IN[0] [*2] |-> !SAFETY_SWITCHING_OUTPUT[0])
    else $error("output high, input low");
  err_low_a: assert property (
    ERROR_OUT[0] [*2] |-> !SAFETY_SWITCHING_OUTPUT[0])
    else $error("output high, error set");
  led_low_a: assert property (
    CLEAR_LED[0] |=> !SAFETY_SWITCHING_OUTPUT[0])
    else $error("output high, led flashing");
  err_clear_a: assert property (
    $fell(ERROR_OUT[0]) |-> BVALID || $past(BVALID))
    else $error("error flag dropped alone");
  status_write_a: assert property (
    !$stable(STATUS_OUT) |-> BVALID || $past(BVALID))
    else $error("status moved alone");
  rd_answer_a: assert property (
    ARVALID && ARREADY |=> RVALID) else $error("read answer late");
  wr_answer_a: assert property (
    AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write answer late");
  relay_off_a: assert property (
    !RELAY_IN[0] [*2] |-> !RELAY_COIL[0])
    else $error("relay closed, input low");
  cover property (ERROR_OUT[0]);
  cover property ($rose(SAFETY_SWITCHING_OUTPUT[0]));
  cover property ($rose(RELAY_COIL[0]));
endmodule : sofb_sva
`default_nettype wire

// ==== tb/sofb_contactor_model.sv ====
// sofb_contactor_model: external contactors, relays and restart loop.
// assumes outputs sampled on clk; relay coils fed straight back unsampled.
`default_nettype none
module sofb_contactor_model (
  // clock and fault control
  input wire logic clk,
  input wire logic stuck,
  // from the device
  input wire logic [3:0] coil_out,
  input wire logic [3:0] relay_coil,
  // back to the device
  output logic [3:0] feedback,
  output logic [3:0] restart_fb,
  output logic [3:0] readback,
  output logic [3:0] ext_fb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] d1_q, d2_q;
  // armature lags the coil by two cycles
  always_ff @(posedge clk)
  begin
    d1_q <= coil_out;
    d2_q <= d1_q;
  end
  assign feedback = stuck ? 4'hF : ~d2_q;
  assign restart_fb = 4'hF;
  assign readback = relay_coil;
  assign ext_fb = ~relay_coil;
endmodule : sofb_contactor_model
`default_nettype wire

// ==== tb/test_safety_output_function_blocks.sv ====
// test_safety_output_function_blocks: self-checking bench.
// assumes sofb_top, contactor model and checker compiled first.
`default_nettype none
module test_safety_output_function_blocks;
  import sofb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RESETN = 1'b0, stuck = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, FIELDBUS_PROBE;
  logic [3:0] WSTRB = 4'hF, BLOCK_IN = 4'h0, RESET_IN = 4'h0;
  logic [3:0] RELAY_IN = 4'h0, RELAY_START = 4'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP;
  logic [3:0] CONTACTOR_FEEDBACK, RESTART_FEEDBACK_INPUT, CLEAR_LED;
  logic [3:0] SAFETY_SWITCHING_OUTPUT, ERROR_OUT, RESTART_FEEDBACK_USED;
  logic [3:0] RELAY_READBACK, RELAY_EXT_FEEDBACK, RELAY_COIL, STATUS_OUT;
  logic [3:0] OUTPUT_TEST_EQUIPMENT_SIGNAL;
  int failures = 0, samples_checked = 0;

  sofb_top u_dut (.*);
  sofb_contactor_model u_load (
    .clk(CLK),
    .stuck(stuck),
    .coil_out(SAFETY_SWITCHING_OUTPUT),
    .relay_coil(RELAY_COIL),
    .feedback(CONTACTOR_FEEDBACK),
    .restart_fb(RESTART_FEEDBACK_INPUT),
    .readback(RELAY_READBACK),
    .ext_fb(RELAY_EXT_FEEDBACK)
  );

  always #20 CLK = ~CLK;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic settle();
    repeat (8) @(posedge CLK);
  endtask : settle

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    bit aw, w;
    aw = 0;
    w = 0;
    // let an edge pass so the last call's release is seen first
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge CLK);
      aw = aw | AWREADY;
      w = w | WREADY;
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
    end
    do @(posedge CLK); while (!BVALID);
    BREADY <= 1'b0;
    chk({30'h0, BRESP}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (!RVALID);
    RREADY <= 1'b0;
    if (er == 2'b00) chk(RDATA, e);
    chk({30'h0, RRESP}, {30'h0, er});
  endtask : rd

  task automatic t_regs();
    rd(OFS_CTRL, CTRL_RST, 2'b00);
    rd(OFS_FBKTIME, {16'h0, FBKTIME_RST}, 2'b00);
    rd(8'h1C, 32'h0, 2'b10);
    wr(OFS_STATUS, 32'h0, 2'b10);
    wr(OFS_NODES, 32'hA, 2'b00);
    settle();
    chk(STATUS_OUT, 4'hA);
    chk(FIELDBUS_PROBE, 32'h0000_000A);
    $display("regs test done");
  endtask : t_regs

  task automatic t_direct();
    int lo1, lo3;
    lo1 = 0;
    lo3 = 0;
    wr(OFS_CHCFG, 32'h0010_1010, 2'b00);
    BLOCK_IN <= 4'hF;
    settle();
    chk(SAFETY_SWITCHING_OUTPUT[2:0], 3'h7);
    // one full test pulse period
    repeat (25010)
    begin
      @(posedge CLK);
      lo1 += !SAFETY_SWITCHING_OUTPUT[1];
      lo3 += !SAFETY_SWITCHING_OUTPUT[3];
    end
    chk(lo1, 0);
    chk(lo3 > 0, 1);
    BLOCK_IN <= 4'h0;
    settle();
    chk(SAFETY_SWITCHING_OUTPUT, 4'h0);
    $display("direct test done");
  endtask : t_direct

  task automatic t_manual();
    wr(OFS_CHCFG, 32'h1010_1011, 2'b00);
    BLOCK_IN <= 4'h1;
    settle();
    chk(SAFETY_SWITCHING_OUTPUT[0], 1'b0);
    chk(RESTART_FEEDBACK_USED[1:0], 2'h1);
    RESET_IN <= 4'h1;
    settle();
    chk(SAFETY_SWITCHING_OUTPUT[0], 1'b1);
    BLOCK_IN <= 4'h0;
    settle();
    BLOCK_IN <= 4'h1;
    settle();
    chk(SAFETY_SWITCHING_OUTPUT[0], 1'b0);
    RESET_IN <= 4'h0;
    settle();
    RESET_IN <= 4'h1;
    settle();
    chk(SAFETY_SWITCHING_OUTPUT[0], 1'b1);
    BLOCK_IN <= 4'h0;
    RESET_IN <= 4'h0;
    $display("manual test done");
  endtask : t_manual

  task automatic t_monitored();
    wr(OFS_CHCFG, 32'h1010_1013, 2'b00);
    BLOCK_IN <= 4'h1;
    RESET_IN <= 4'h1;
    settle();
    chk(SAFETY_SWITCHING_OUTPUT[0], 1'b0);
    RESET_IN <= 4'h0;
    settle();
    chk(SAFETY_SWITCHING_OUTPUT[0], 1'b1);
    BLOCK_IN <= 4'h0;
    $display("monitored test done");
  endtask : t_monitored

  task automatic t_fault();
    int n;
    n = 0;
    wr(OFS_FBKTIME, 32'h1, 2'b00);
    wr(OFS_CHCFG, 32'h1010_101C, 2'b00);
    stuck <= 1'b1;
    BLOCK_IN <= 4'h1;
    while (ERROR_OUT[0] !== 1'b1 && n < 30000)
    begin
      @(posedge CLK);
      n++;
    end
    chk(ERROR_OUT[0], 1'b1);
    // output drops one edge after the fault latches
    @(posedge CLK);
    chk(SAFETY_SWITCHING_OUTPUT[0], 1'b0);
    stuck <= 1'b0;
    settle();
    chk(ERROR_OUT[0], 1'b1);
    wr(OFS_CTRL, 32'h8, 2'b00);
    settle();
    chk(ERROR_OUT[0], 1'b0);
    BLOCK_IN <= 4'h0;
    $display("fault test done");
  endtask : t_fault

  task automatic t_relay();
    RELAY_IN <= 4'h1;
    settle();
    chk(RELAY_COIL[0], 1'b1);
    RELAY_IN <= 4'h0;
    wr(OFS_RLYCFG, 32'h1, 2'b00);
    settle();
    chk(OUTPUT_TEST_EQUIPMENT_SIGNAL[0], 1'b1);
    wr(OFS_RLYCFG, 32'h0202, 2'b00);
    RELAY_IN <= 4'h1;
    settle();
    chk(RELAY_COIL[1:0], 2'h3);
    RELAY_IN <= 4'h0;
    $display("relay test done");
  endtask : t_relay

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  initial
  begin
    #(90000 * 40);
    failures++;
    complete_run();
  end

  initial
  begin
    repeat (6) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    t_regs();
    t_direct();
    t_manual();
    t_monitored();
    t_fault();
    t_relay();
    complete_run();
  end
endmodule : test_safety_output_function_blocks

bind sofb_top sofb_sva u_sva (.*);
`default_nettype wire
